// ---- hdl/sws_defines.svh ----
// register offsets, field positions, reset values and opcodes for the subtract unit
// assumes it is included by bare name from the core module and the testbench
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH

// register byte addresses on the bus
`define SWS_ADDR_INSTR       8'h00
`define SWS_ADDR_ACC         8'h04
`define SWS_ADDR_BANK        8'h08
`define SWS_ADDR_STATUS      8'h0C
`define SWS_ADDR_FADDR       8'h10
`define SWS_ADDR_FDATA       8'h14

// status register bit positions
`define SWS_ST_CARRY         0
`define SWS_ST_NIBBLE        1
`define SWS_ST_ZERO          2
`define SWS_ST_OVERFLOW      3
`define SWS_ST_NEGATIVE      4
`define SWS_ST_BUSY          8
`define SWS_ST_ILLEGAL       9

// instruction fields
`define SWS_OPC_LIT          8'h08
`define SWS_OPC_FILE         6'h17
`define SWS_BIT_DEST         9
`define SWS_BIT_BANK         8

// access bank halves
`define SWS_ACCESS_LOW_BANK  4'h0
`define SWS_ACCESS_HIGH_BANK 4'hF

// reset values
`define SWS_ACC_RST          8'h00
`define SWS_BANK_RST         4'h0
`define SWS_INSTR_RST        16'h0000
`define SWS_FADDR_RST        12'h000

// bus responses
`define SWS_RESP_OKAY        2'h0
`define SWS_RESP_SLVERR      2'h2

`endif

// ---- hdl/sws_pkg.sv ----
// types shared by the subtract unit modules
// assumes nothing beyond a SystemVerilog compiler
package sws_pkg;

    // instruction cycle phases, one-hot
    typedef enum logic [4:0] {
        SWS_IDLE = 5'h01,
        SWS_Q1   = 5'h02,
        SWS_Q2   = 5'h04,
        SWS_Q3   = 5'h08,
        SWS_Q4   = 5'h10
    } sws_phase_t;

    // arithmetic flags
    typedef struct packed {
        logic negative_flag;
        logic overflow_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
    } sws_flags_t;

endpackage

// ---- hdl/sws_alu_if.sv ----
// carrier between the core sequencer and the subtract datapath
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none

interface sws_alu_if;
    import sws_pkg::*;
    logic [7:0] minuend;     // file value or literal
    logic [7:0] subtrahend;  // accumulator
    logic [7:0] diff;        // difference
    sws_flags_t flags;       // resulting flags

    modport core (output minuend, output subtrahend, input diff, input flags);
    modport unit (input minuend, input subtrahend, output diff, output flags);
endinterface

`default_nettype wire

// ---- hdl/sws_sub_unit.sv ----
// combinational two's complement subtractor with flag generation
// assumes operands are held stable by the sequencer during the process phase
`timescale 1ns/100ps
`default_nettype none

module sws_sub_unit
    import sws_pkg::*;
(
    sws_alu_if.unit alu
);

    logic [8:0] full_sum;   // a + ~b + 1, bit 8 is not-borrow
    logic [4:0] low_sum;    // low nibble of the same sum

    // subtract by adding the complement plus one
    assign full_sum = {1'b0, alu.minuend} + {1'b0, ~alu.subtrahend} + 9'h001;
    assign low_sum  = {1'b0, alu.minuend[3:0]} + {1'b0, ~alu.subtrahend[3:0]} + 5'h01;
    assign alu.diff = full_sum[7:0];

    // carry set when no borrow, cleared on borrow
    assign alu.flags.carry_flag        = full_sum[8];
    assign alu.flags.nibble_carry_flag = low_sum[4];
    assign alu.flags.zero_flag         = (full_sum[7:0] == 8'h00);
    assign alu.flags.negative_flag     = full_sum[7];
    // signed overflow: operand signs differ and result sign leaves minuend
    assign alu.flags.overflow_flag     = (alu.minuend[7] ^ alu.subtrahend[7]) &
                                         (full_sum[7] ^ alu.minuend[7]);

endmodule

`default_nettype wire

// ---- hdl/sws_core.sv ----
// subtract instruction unit with an AXI4-Lite register slave
// assumes a single 40 MHz clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "sws_defines.svh"

module sws_core
    import sws_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    // byte-strobe merge of a write into an old register value
    function automatic logic [31:0] sws_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // file address resolution from bank bit, bank pointer and address field
    function automatic logic [11:0] sws_ea(input logic       bank_sel,
                                           input logic [3:0] bank_ptr,
                                           input logic [7:0] field);
        logic [11:0] res;
        if (bank_sel) begin
            res = {bank_ptr, field};
        end else if (field[7]) begin
            res = {`SWS_ACCESS_HIGH_BANK, field};
        end else begin
            res = {`SWS_ACCESS_LOW_BANK, field};
        end
        return res;
    endfunction

    // bus handshake state
    logic        awready_q;          // write address accepted when high
    logic        wready_q;           // write data accepted when high
    logic        bvalid_q;           // write response pending
    logic [1:0]  bresp_q;            // write response code
    logic        arready_q;          // read address accepted when high
    logic        rvalid_q;           // read data pending
    logic [1:0]  rresp_q;            // read response code
    logic [31:0] rdata_q;            // read data
    logic        aw_have_q;          // address held
    logic [7:0]  aw_addr_q;          // held write address
    logic        w_have_q;           // data held
    logic [31:0] w_data_q;           // held write data
    logic [3:0]  w_strb_q;           // held byte strobes

    // architectural state
    logic [7:0]  acc_q;              // working accumulator
    logic [3:0]  bank_pointer_register_q; // bank pointer
    sws_flags_t  flags_q;            // arithmetic flags
    logic        illegal_q;          // last instruction not recognised
    logic [15:0] instr_q;            // instruction being run
    logic [11:0] faddr_q;            // file window address
    logic [7:0]  file_mem [0:4095];  // file register space

    // execution state
    sws_phase_t  phase_q;            // current phase
    sws_phase_t  phase_d;            // next phase
    logic        op_lit_q;           // literal form decoded
    logic        op_file_q;          // file form decoded
    logic        dest_q;             // destination bit
    logic [11:0] ea_q;               // resolved file address
    logic [7:0]  opnd_q;             // minuend read in phase two
    logic [7:0]  diff_q;             // processed difference
    sws_flags_t  res_flags_q;        // processed flags

    sws_alu_if   alu ();

    // datapath instance
    sws_sub_unit u_sub (
        .alu (alu)
    );

    // decode of the held write and the incoming read
    logic        idle_w;
    logic        wr_go;
    logic        hit_instr, hit_acc, hit_bank, hit_faddr, hit_fdata, hit_status;
    logic        wr_ok;
    logic [31:0] wr_acc_m, wr_bank_m, wr_instr_m, wr_faddr_m, wr_fdata_m;
    logic        rd_go;
    logic        rd_ok;
    logic [31:0] status_w;
    logic [31:0] rd_word;
    logic        is_lit_w;
    logic        is_file_w;
    logic        start_w;

    assign idle_w     = (phase_q == SWS_IDLE);
    // writes wait while an instruction runs, so state never has two writers
    assign wr_go      = aw_have_q & w_have_q & ~bvalid_q & idle_w;
    assign hit_instr  = (aw_addr_q == `SWS_ADDR_INSTR);
    assign hit_acc    = (aw_addr_q == `SWS_ADDR_ACC);
    assign hit_bank   = (aw_addr_q == `SWS_ADDR_BANK);
    assign hit_status = (aw_addr_q == `SWS_ADDR_STATUS);
    assign hit_faddr  = (aw_addr_q == `SWS_ADDR_FADDR);
    assign hit_fdata  = (aw_addr_q == `SWS_ADDR_FDATA);
    assign wr_ok      = hit_instr | hit_acc | hit_bank | hit_status | hit_faddr | hit_fdata;
    assign wr_instr_m = sws_merge({16'h0000, instr_q}, w_data_q, w_strb_q);
    assign wr_acc_m   = sws_merge({24'h000000, acc_q}, w_data_q, w_strb_q);
    assign wr_bank_m  = sws_merge({28'h0000000, bank_pointer_register_q}, w_data_q, w_strb_q);
    assign wr_faddr_m = sws_merge({20'h00000, faddr_q}, w_data_q, w_strb_q);
    assign wr_fdata_m = sws_merge({24'h000000, file_mem[faddr_q]}, w_data_q, w_strb_q);
    assign start_w    = wr_go & hit_instr;

    assign rd_go    = ARVALID & arready_q;
    assign status_w = {22'h000000, illegal_q, ~idle_w, 3'h0,
                       flags_q.negative_flag, flags_q.overflow_flag, flags_q.zero_flag,
                       flags_q.nibble_carry_flag, flags_q.carry_flag};
    assign rd_ok    = (ARADDR == `SWS_ADDR_INSTR) | (ARADDR == `SWS_ADDR_ACC) |
                      (ARADDR == `SWS_ADDR_BANK) | (ARADDR == `SWS_ADDR_STATUS) |
                      (ARADDR == `SWS_ADDR_FADDR) | (ARADDR == `SWS_ADDR_FDATA);
    assign rd_word  = (ARADDR == `SWS_ADDR_INSTR)  ? {16'h0000, instr_q} :
                      (ARADDR == `SWS_ADDR_ACC)    ? {24'h000000, acc_q} :
                      (ARADDR == `SWS_ADDR_BANK)   ? {28'h0000000, bank_pointer_register_q} :
                      (ARADDR == `SWS_ADDR_STATUS) ? status_w :
                      (ARADDR == `SWS_ADDR_FADDR)  ? {20'h00000, faddr_q} :
                      (ARADDR == `SWS_ADDR_FDATA)  ? {24'h000000, file_mem[faddr_q]} :
                                                     32'h00000000;

    // opcode recognition
    assign is_lit_w  = (instr_q[15:8] == `SWS_OPC_LIT);
    assign is_file_w = (instr_q[15:10] == `SWS_OPC_FILE);

    // datapath operands: minuend minus accumulator
    assign alu.minuend    = opnd_q;
    assign alu.subtrahend = acc_q;

    // write address and data channels, taken in either order
    always_ff @(posedge CLK) begin
        if (RESET) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            if (AWVALID & awready_q) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= AWADDR;
                awready_q <= 1'b0;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end else if (bvalid_q & BREADY) begin
                awready_q <= 1'b1;
            end
            if (WVALID & wready_q) begin
                w_have_q <= 1'b1;
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
                wready_q <= 1'b0;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end else if (bvalid_q & BREADY) begin
                wready_q <= 1'b1;
            end
        end
    end

    // write response after both halves commit
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `SWS_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? `SWS_RESP_OKAY : `SWS_RESP_SLVERR;
        end else if (bvalid_q & BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel, one cycle to data
    always_ff @(posedge CLK) begin
        if (RESET) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `SWS_RESP_OKAY;
            rdata_q   <= 32'h00000000;
        end else if (rd_go) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= rd_ok ? `SWS_RESP_OKAY : `SWS_RESP_SLVERR;
            rdata_q   <= rd_word;
        end else if (rvalid_q & RREADY) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end

    // phase sequencer: decode, read, process, write
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            SWS_IDLE: phase_d = start_w ? SWS_Q1 : SWS_IDLE;
            SWS_Q1:   phase_d = SWS_Q2;
            SWS_Q2:   phase_d = SWS_Q3;
            SWS_Q3:   phase_d = SWS_Q4;
            SWS_Q4:   phase_d = SWS_IDLE;
        endcase
    end

    // phase register
    always_ff @(posedge CLK) begin
        if (RESET) begin
            phase_q <= SWS_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // first phase: decode opcode, destination and file address
    always_ff @(posedge CLK) begin
        if (RESET) begin
            op_lit_q  <= 1'b0;
            op_file_q <= 1'b0;
            dest_q    <= 1'b0;
            ea_q      <= 12'h000;
            illegal_q <= 1'b0;
        end else if (phase_q == SWS_Q1) begin
            op_lit_q  <= is_lit_w;
            op_file_q <= is_file_w;
            dest_q    <= instr_q[`SWS_BIT_DEST];
            // access bank or bank pointer
            ea_q      <= sws_ea(instr_q[`SWS_BIT_BANK], bank_pointer_register_q,
                                instr_q[7:0]);
            illegal_q <= ~(is_lit_w | is_file_w);
        end
    end

    // second and third phases: fetch operand, then latch difference and flags
    always_ff @(posedge CLK) begin
        if (RESET) begin
            opnd_q      <= 8'h00;
            diff_q      <= 8'h00;
            res_flags_q <= '0;
        end else if (phase_q == SWS_Q2) begin
            opnd_q <= op_lit_q ? instr_q[7:0] : file_mem[ea_q];
        end else if (phase_q == SWS_Q3) begin
            diff_q      <= alu.diff;
            res_flags_q <= alu.flags;
        end
    end

    // accumulator, bank pointer, flags, instruction and window address
    always_ff @(posedge CLK) begin
        if (RESET) begin
            acc_q                   <= `SWS_ACC_RST;
            bank_pointer_register_q <= `SWS_BANK_RST;
            flags_q                 <= '0;
            instr_q                 <= `SWS_INSTR_RST;
            faddr_q                 <= `SWS_FADDR_RST;
        end else if (phase_q == SWS_Q4) begin
            // difference to accumulator for literal form or destination 0
            if (op_lit_q | (op_file_q & ~dest_q)) begin
                acc_q <= diff_q;
            end
            if (op_lit_q | op_file_q) begin
                flags_q <= res_flags_q;
            end
        end else if (wr_go) begin
            if (hit_acc)   acc_q                   <= wr_acc_m[7:0];
            if (hit_bank)  bank_pointer_register_q <= wr_bank_m[3:0];
            if (hit_instr) instr_q                 <= wr_instr_m[15:0];
            if (hit_faddr) faddr_q                 <= wr_faddr_m[11:0];
        end
    end

    // file register space: instruction write-back or bus window write
    always_ff @(posedge CLK) begin
        if ((phase_q == SWS_Q4) & op_file_q & dest_q) begin
            file_mem[ea_q] <= diff_q;
        end else if (wr_go & hit_fdata) begin
            file_mem[faddr_q] <= wr_fdata_m[7:0];
        end
    end

    // outputs straight from flip-flops
    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RRESP   = rresp_q;
    assign RDATA   = rdata_q;

endmodule

`default_nettype wire

// ---- test/sws_core_sva.sv ----
// bus-level checks for the subtract unit register slave
// assumes it is bound to sws_core and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module sws_core_sva (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic [7:0]  AWADDR,
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0]  WSTRB,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [7:0]  ARADDR,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    input wire logic        RREADY
);
    // one clock domain, checks off while reset is high
    default clocking clk_cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_b_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
    property p_r_answer; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_done; RVALID && RREADY |=> !RVALID && ARREADY; endproperty
    a_r_done: assert property (p_r_done) else $error("read channel not released");
    property p_b_done; BVALID && BREADY |=> !BVALID && AWREADY && WREADY; endproperty
    a_b_done: assert property (p_b_done) else $error("write channel not released");
    property p_aw_block; AWVALID && AWREADY |=> !AWREADY; endproperty
    a_aw_block: assert property (p_aw_block) else $error("second write taken early");
    // a write waits at most for the running instruction to finish
    property p_w_answer; AWVALID && AWREADY && WVALID && WREADY |-> ##[1:8] BVALID; endproperty
    a_w_answer: assert property (p_w_answer) else $error("write answer late");
    property p_b_code; BVALID |-> BRESP == 2'h0 || BRESP == 2'h2; endproperty
    a_b_code: assert property (p_b_code) else $error("bad write response code");
    property p_err_zero; RVALID && RRESP == 2'h2 |-> RDATA == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read carries data");

    // main scenarios reached
    c_w_err: cover property (BVALID && BRESP == 2'h2);
    c_r_err: cover property (RVALID && RRESP == 2'h2);
    c_w_stall: cover property ((!AWREADY && !BVALID) [*2]);
endmodule

`default_nettype wire

// ---- test/tb_sws_core.sv ----
// self-checking bench driving the subtract unit through its register bus
// assumes the package, the design and the checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "sws_defines.svh"

module tb_sws_core;
    import sws_pkg::*;
    logic        CLK, RESET;              // clock and reset driven here
    logic [7:0]  AWADDR, ARADDR;          // byte addresses
    logic        AWVALID, WVALID, BREADY; // write side handshakes
    logic        ARVALID, RREADY;         // read side handshakes
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0]  BRESP, RRESP;
    int          fails, checks_done, cyc;
    logic [4:0]  lastf;                   // flags left by the last legal instruction

    sws_core uut (.CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // 25 ns clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    // one write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK);
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, BRESP});
    endtask

    // one read, answer taken at the edge where it is seen
    task automatic rdq(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        do begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        d = RDATA;
        r = RRESP;
    endtask

    // read and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rdq(a, d, r);
        chk("read data", e, d);
        chk("read response", {30'h0, er}, {30'h0, r});
    endtask

    // poll status until the unit is no longer busy
    task automatic idle;
        logic [31:0] d;
        logic [1:0]  r;
        do begin
            rdq(`SWS_ADDR_STATUS, d, r);
        end while (d[`SWS_ST_BUSY] !== 1'b0);
    endtask

    // reference {negative, overflow, zero, nibble carry, carry, difference}
    function automatic logic [12:0] ref_sub(input logic [7:0] m, input logic [7:0] w);
        logic [7:0] r;
        r = m - w;
        return {r[7], (m[7] != w[7]) && (r[7] != m[7]), r == 8'h00,
                m[3:0] >= w[3:0], m >= w, r};
    endfunction

    // literal form: literal minus accumulator into accumulator
    task automatic lit(input logic [7:0] k, input logic [7:0] w);
        logic [12:0] e;
        e = ref_sub(k, w);
        wr(`SWS_ADDR_ACC, {24'h0, w}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_INSTR, {16'h0, `SWS_OPC_LIT, k}, `SWS_RESP_OKAY);
        idle();
        rd(`SWS_ADDR_ACC, {24'h0, e[7:0]}, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_STATUS, {27'h0, e[12:8]}, `SWS_RESP_OKAY);
        lastf = e[12:8];
    endtask

    // file form: preload the resolved cell, run, check both destinations
    task automatic fil(input logic [11:0] pa, input logic [7:0] m, input logic [3:0] bk,
                       input logic [7:0] w, input logic d, input logic ab, input logic [7:0] fa);
        logic [12:0] e;
        e = ref_sub(m, w);
        wr(`SWS_ADDR_FADDR, {20'h0, pa}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_FDATA, {24'h0, m}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_BANK, {28'h0, bk}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_ACC, {24'h0, w}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_INSTR, {16'h0, `SWS_OPC_FILE, d, ab, fa}, `SWS_RESP_OKAY);
        idle();
        rd(`SWS_ADDR_ACC, {24'h0, d ? w : e[7:0]}, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_FDATA, {24'h0, d ? e[7:0] : m}, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_STATUS, {27'h0, e[12:8]}, `SWS_RESP_OKAY);
        lastf = e[12:8];
    endtask

    // print counts and verdict, then stop
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    initial begin
        cyc = 0;
        forever begin
            @(posedge CLK);
            cyc++;
            if (cyc == 20000) begin
                fails++;
                wrap_up();
            end
        end
    end

    // literal cases, file cases: cell, data, bank, acc, dest, bank bit, field
    logic [7:0]  lk [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10};
    logic [7:0]  lw [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01};
    logic [11:0] fp [4] = '{12'h385, 12'hF85, 12'h020, 12'h5FF};
    logic [7:0]  fm [4] = '{8'h50, 8'h01, 8'h03, 8'h7F};
    logic [3:0]  fb [4] = '{4'h3, 4'h5, 4'h5, 4'h5};
    logic [7:0]  fw [4] = '{8'h20, 8'h02, 8'h02, 8'hFF};
    logic [3:0]  fx [4] = '{4'h3, 4'h0, 4'h2, 4'h1};
    logic [7:0]  fa [4] = '{8'h85, 8'h85, 8'h20, 8'hFF};
    logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

    // main sequence
    initial begin
        RESET = 1'b1;
        AWADDR = 8'h00;
        ARADDR = 8'h00;
        WDATA = 32'h0;
        WSTRB = 4'hF;
        AWVALID = 1'b0;
        WVALID = 1'b0;
        BREADY = 1'b0;
        ARVALID = 1'b0;
        RREADY = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        foreach (ra[i]) rd(ra[i], 32'h0, `SWS_RESP_OKAY);
        foreach (lk[i]) lit(lk[i], lw[i]);
        foreach (fp[i]) fil(fp[i], fm[i], fb[i], fw[i], fx[i][1], fx[i][0], fa[i]);
        wr(`SWS_ADDR_INSTR, 32'h0000FFFF, `SWS_RESP_OKAY);
        idle();
        rd(`SWS_ADDR_STATUS, {22'h0, 2'b10, 3'h0, lastf}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_STATUS, 32'h0000001F, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_STATUS, {22'h0, 2'b10, 3'h0, lastf}, `SWS_RESP_OKAY);
        // a write during a running instruction waits and lands after its result
        wr(`SWS_ADDR_INSTR, {16'h0, `SWS_OPC_LIT, 8'h05}, `SWS_RESP_OKAY);
        wr(`SWS_ADDR_ACC, 32'h0000005A, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_ACC, 32'h0000005A, `SWS_RESP_OKAY);
        // a masked byte lane leaves the accumulator alone
        WSTRB <= 4'hE;
        wr(`SWS_ADDR_ACC, 32'h000000C3, `SWS_RESP_OKAY);
        rd(`SWS_ADDR_ACC, 32'h0000005A, `SWS_RESP_OKAY);
        WSTRB <= 4'hF;
        wr(8'h18, 32'h000000AA, `SWS_RESP_SLVERR);
        rd(8'h18, 32'h0, `SWS_RESP_SLVERR);
        wrap_up();
    end
endmodule

bind sws_core sws_core_sva chk (.CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

`default_nettype wire
